/* hw/lsc_pkg.sv */
// shared constants and types for the segment display scan controller
package lsc_pkg;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [15:0] ADDR_DATA_BASE = 16'hA100;
	localparam logic [15:0] ADDR_DIV_LOW = 16'hA120;
	localparam logic [15:0] ADDR_DIV_HIGH = 16'hA121;
	localparam logic [15:0] ADDR_CFG_A = 16'hA122;
	localparam logic [15:0] ADDR_CFG_B = 16'hA123;
	localparam logic [15:0] ADDR_CFG_C = 16'hA124;
	localparam int DATA_BYTES = 32;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [7:0] RST_DIV_LOW = 8'h00;
	localparam logic [7:0] RST_DIV_HIGH = 8'h00;
	localparam logic [7:0] RST_CFG_A = 8'h00;
	localparam logic [7:0] RST_CFG_B = 8'h00;
	localparam logic [7:0] RST_CFG_C = 8'h00;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int POS_CLK_SEL = 7;
	localparam int POS_MODE = 5;
	localparam int POS_GLASS_BRT_HI = 4;
	localparam int POS_DIV_HI = 0;
	localparam int POS_COM_EN = 4;
	localparam int POS_BLANK = 3;
	localparam int POS_IRQ_EN = 1;
	localparam int POS_IRQ_FLAG = 0;
	localparam int POS_BIAS = 6;
	localparam int POS_GLASS_BRT_LO = 4;
	localparam int POS_SHARED_CNT = 0;
	localparam int POS_SEG_POL = 7;
	localparam int POS_COM_POL = 6;
	localparam int POS_MATRIX_BRT = 0;
	// writable bits of config A; bit 2 reserved, flag handled apart
	localparam logic [7:0] CFG_A_WR_MASK = 8'hFA;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int LED_PRESCALE = 256;
	localparam logic [7:0] PRESCALE_LAST = 8'(LED_PRESCALE - 1);

	// operating mode, in field encoding order
	typedef enum logic [1:0] {
		LSC_OFF,
		LSC_LCD,
		LSC_LED_EXT,
		LSC_LED_DIRECT
	} lsc_mode_t;

endpackage

/* hw/lsc_mem_if.sv */
// link between the scan controller and its display data memory
`timescale 1ns/1ps
`default_nettype none
interface lsc_mem_if;
	logic wrEn;
	logic [4:0] addr;
	logic [7:0] wrData;
	logic rdEn;
	logic rdArray;
	logic [7:0] ctlByte;
	logic [7:0] rdData;
	logic [3:0] slot;
	logic [31:0] column;
	logic [7:0] digitByte;
	modport ctrl(output wrEn, addr, wrData, rdEn, rdArray, ctlByte, slot,
		input rdData, column, digitByte);
	modport mem(input wrEn, addr, wrData, rdEn, rdArray, ctlByte, slot,
		output rdData, column, digitByte);
endinterface
`default_nettype wire

/* hw/lsc_display_mem.sv */
// display data bytes with registered bus read and scan read ports
`timescale 1ns/1ps
`default_nettype none
module lsc_display_mem import lsc_pkg::*; (
	input wire logic clk,
	input wire logic srst,
	lsc_mem_if.mem port
);
	logic [7:0] mem_r [DATA_BYTES];
	logic [7:0] rdData_r;
	logic [31:0] column_r;
	logic [7:0] digit_r;
	logic [31:0] columnNxt;

	// bit of each byte picked by the current common slot
	for (genvar i = 0; i < DATA_BYTES; i++) begin : g_col
		assign columnNxt[i] = mem_r[i][port.slot[2:0]];
	end

	// storage; read mux also returns control bytes so data leave a flop
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < DATA_BYTES; i++) begin
				mem_r[i] <= RST_DATA;
			end
			rdData_r <= RST_DATA;
			column_r <= 32'h00000000;
			digit_r <= RST_DATA;
		end else begin
			if (port.wrEn) begin
				mem_r[port.addr] <= port.wrData;
			end
			if (port.rdEn) begin
				rdData_r <= port.rdArray ? mem_r[port.addr] : port.ctlByte;
			end
			column_r <= columnNxt;
			digit_r <= mem_r[{1'b0, port.slot}];
		end
	end

	assign port.rdData = rdData_r;
	assign port.column = column_r;
	assign port.digitByte = digit_r;
endmodule // lsc_display_mem
`default_nettype wire

/* hw/lsc_scan_ctrl.sv */
// LCD glass and LED matrix scan controller with its register bank
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - mode field: off, LCD, LED external, direct
// - LCD clock: RTC at 0, slow osc at 1
// - LED modes ignore source bit, use sysclk
// - LCD pixel rate: source over divider+1
// - LED pixel rate: sysclk/256/(divider+1)
// - shared pins: 1 common, 0 segment
// - blank bit forces com and seg pins off, scan continues
// - frame end sets flag, enable gates request
// - write 0 clears flag at display tick
// - frame is duty or digit count plus one slots
// - bias field: half, third, quarter
// - glass brightness: three bits, split fields
// - duty code plus one commons scanned
// - direct mode: digit count plus one
// - external mode segment polarity bit
// - external mode common polarity bit
// - LED brightness: 64 levels of slot
// - LCD reference boost lasts field+1 ticks, none at field 0
// - data on segments, or commons in direct
// - segment n shows byte n bit k
// - commons scanned in order then wrap
// - LCD scanning runs while chip sleeps
// - direct mode drives digits in turn
module lsc_scan_ctrl import lsc_pkg::*; (
	input wire logic clk,
	input wire logic srst,
	input wire logic [15:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic rtcClk,
	input wire logic slowOscClk,
	output logic [7:0] comPin,
	output logic [31:0] segPin,
	output logic frameIrq,
	output logic [1:0] glassBias,
	output logic [2:0] glassBrightness,
	output logic refBoost
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] lscOneHot(input logic [3:0] idx);
		lscOneHot = 16'h0001 << idx;
	endfunction

	function automatic logic [3:0] lscRev4(input logic [3:0] v);
		lscRev4 = {v[0], v[1], v[2], v[3]};
	endfunction

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [7:0] divLow_r;
	logic [7:0] ctlHigh_r;
	logic [7:0] cfgA_r;
	logic [7:0] cfgB_r;
	logic [7:0] cfgC_r;
	logic flag_r;
	logic clrPend_r;
	logic rtcPrev_r;
	logic oscPrev_r;
	logic [7:0] pre_r;
	logic [11:0] divCnt_r;
	logic [3:0] slot_r;
	logic [3:0] slotD_r;
	logic [4:0] boostCnt_r;
	logic [7:0] comPin_r;
	logic [31:0] segPin_r;
	logic frameIrq_r;
	logic [1:0] glassBias_r;
	logic [2:0] glassBrt_r;
	logic refBoost_r;

	logic hitData;
	logic hitDivLow;
	logic hitDivHigh;
	logic hitCfgA;
	logic hitCfgB;
	logic hitCfgC;
	logic [7:0] rdCtl;
	logic [7:0] cfgANxt;
	logic clrReq;
	lsc_mode_t mode;
	logic isLcd;
	logic isLed;
	logic isExt;
	logic isDirect;
	logic rtcRise;
	logic oscRise;
	logic srcTick;
	logic [11:0] cslVal;
	logic pixTick;
	logic [3:0] sharedCnt;
	logic [3:0] lastSlot;
	logic slotWrap;
	logic frameEnd;
	logic flagNxt;
	logic clrPendNxt;
	logic [3:0] racVal;
	logic [4:0] boostNxt;
	logic pwmOn;
	logic [15:0] slotHot;
	logic [7:0] comAct;
	logic [31:0] segAct;
	logic [7:0] comKeep;
	logic [31:0] segKeep;
	logic comPolEff;
	logic segPolEff;

	lsc_mem_if mi();

	lsc_display_mem lsc_display_mem_inst (
		.clk(clk),
		.srst(srst),
		.port(mi.mem)
	);

	// ----------------------------------------
	// register bus decode
	// ----------------------------------------
	// unmapped addresses read 0x00, writes to them are dropped
	assign hitData = regAddr[15:5] == ADDR_DATA_BASE[15:5];
	assign hitDivLow = regAddr == ADDR_DIV_LOW;
	assign hitDivHigh = regAddr == ADDR_DIV_HIGH;
	assign hitCfgA = regAddr == ADDR_CFG_A;
	assign hitCfgB = regAddr == ADDR_CFG_B;
	assign hitCfgC = regAddr == ADDR_CFG_C;
	assign rdCtl = hitDivLow ? divLow_r :
		hitDivHigh ? ctlHigh_r :
		hitCfgA ? (cfgA_r | {7'h00, flag_r}) :
		hitCfgB ? cfgB_r :
		hitCfgC ? cfgC_r : 8'h00;
	assign cfgANxt = (regWr && hitCfgA) ? (regWrData & CFG_A_WR_MASK)
		: cfgA_r;
	// writing 1 to the flag does nothing; only 0 clears
	assign clrReq = regWr && hitCfgA && !regWrData[POS_IRQ_FLAG];

	// memory port; read data come back one cycle later from its flop
	assign mi.wrEn = regWr && hitData;
	assign mi.addr = regAddr[4:0];
	assign mi.wrData = regWrData;
	assign mi.rdEn = regRd;
	assign mi.rdArray = hitData;
	assign mi.ctlByte = rdCtl;
	assign mi.slot = slot_r;

	// control registers
	always_ff @(posedge clk) begin
		if (srst) begin
			divLow_r <= RST_DIV_LOW;
			ctlHigh_r <= RST_DIV_HIGH;
			cfgA_r <= RST_CFG_A;
			cfgB_r <= RST_CFG_B;
			cfgC_r <= RST_CFG_C;
		end else if (regWr) begin
			if (hitDivLow) divLow_r <= regWrData;
			if (hitDivHigh) ctlHigh_r <= regWrData;
			if (hitCfgB) cfgB_r <= regWrData;
			if (hitCfgC) cfgC_r <= regWrData;
			cfgA_r <= cfgANxt;
		end
	end

	// ----------------------------------------
	// mode and clock source
	// ----------------------------------------
	assign mode = lsc_mode_t'(ctlHigh_r[POS_MODE +: 2]);
	assign isLcd = mode == LSC_LCD;
	assign isExt = mode == LSC_LED_EXT;
	assign isDirect = mode == LSC_LED_DIRECT;
	assign isLed = isExt || isDirect;
	assign rtcRise = rtcClk && !rtcPrev_r;
	assign oscRise = slowOscClk && !oscPrev_r;
	// LCD timing hangs only on the slow clocks, so it keeps going
	// while the rest of the chip sleeps
	assign srcTick = isLcd ? (ctlHigh_r[POS_CLK_SEL] ? oscRise : rtcRise)
		: isLed ? (pre_r == PRESCALE_LAST) : 1'b0;

	// ----------------------------------------
	// pixel divider and scan slots
	// ----------------------------------------
	assign cslVal = {ctlHigh_r[POS_DIV_HI +: 4], divLow_r};
	// >= so a divider lowered mid-count still wraps at once
	assign pixTick = srcTick && (divCnt_r >= cslVal);
	assign sharedCnt = cfgB_r[POS_SHARED_CNT +: 4];
	assign lastSlot = isDirect ? sharedCnt
		: {1'b0, sharedCnt[2:0]};
	assign slotWrap = slot_r >= lastSlot;
	assign frameEnd = pixTick && slotWrap;

	// edge detectors follow the pins even while off, so enabling the
	// controller with a slow clock parked high gives no false tick
	always_ff @(posedge clk) begin
		if (srst) begin
			rtcPrev_r <= 1'b0;
			oscPrev_r <= 1'b0;
		end else begin
			rtcPrev_r <= rtcClk;
			oscPrev_r <= slowOscClk;
		end
	end

	// prescaler, divider and slot counters
	always_ff @(posedge clk) begin
		if (srst || mode == LSC_OFF) begin
			pre_r <= 8'h00;
			divCnt_r <= 12'h000;
			slot_r <= 4'h0;
		end else begin
			pre_r <= isLed ? pre_r + 8'h01 : 8'h00;
			if (srcTick) divCnt_r <= pixTick ? 12'h000 : divCnt_r + 12'h001;
			if (pixTick) slot_r <= slotWrap ? 4'h0 : slot_r + 4'h1;
		end
	end

	// ----------------------------------------
	// reference boost
	// ----------------------------------------
	assign racVal = cfgC_r[POS_MATRIX_BRT +: 4];
	assign boostNxt = (pixTick && isLcd && racVal != 4'h0)
		? {1'b0, racVal} + 5'h01
		: (srcTick && boostCnt_r != 5'h00) ? boostCnt_r - 5'h01
		: isLcd ? boostCnt_r : 5'h00;

	// ----------------------------------------
	// frame flag
	// ----------------------------------------
	// a frame end in the clearing tick wins: the flag stays set
	assign flagNxt = frameEnd ? 1'b1
		: (clrPend_r && srcTick) ? 1'b0 : flag_r;
	assign clrPendNxt = clrReq ? 1'b1 : srcTick ? 1'b0 : clrPend_r;

	always_ff @(posedge clk) begin
		if (srst) begin
			flag_r <= 1'b0;
			clrPend_r <= 1'b0;
			boostCnt_r <= 5'h00;
			frameIrq_r <= 1'b0;
		end else begin
			flag_r <= flagNxt;
			clrPend_r <= clrPendNxt;
			boostCnt_r <= boostNxt;
			frameIrq_r <= flagNxt && cfgANxt[POS_IRQ_EN];
		end
	end

	// ----------------------------------------
	// pin drive
	// ----------------------------------------
	// on-phase within a slot from the prescaler's top six bits
	assign pwmOn = isLed ? (pre_r[7:2] <= cfgC_r[POS_MATRIX_BRT +: 6])
		: isLcd;
	assign slotHot = lscOneHot(slotD_r);
	// glass shows data levels only; analog bias waveforms live outside
	assign comAct = (cfgA_r[POS_BLANK] || !pwmOn) ? 8'h00
		: isDirect ? mi.digitByte
		: slotHot[7:0];
	assign segAct = (cfgA_r[POS_BLANK] || !pwmOn) ? 32'h00000000
		: isDirect ? {16'h0000, slotHot}
		: mi.column;
	// shared pins: common when enabled, otherwise segment
	assign comKeep = {cfgA_r[POS_COM_EN +: 4], 4'hF};
	assign segKeep = {~lscRev4(cfgA_r[POS_COM_EN +: 4]), 28'hFFFFFFF};
	assign comPolEff = isExt && cfgC_r[POS_COM_POL];
	assign segPolEff = isExt && cfgC_r[POS_SEG_POL];

	// every pin leaves a flop; com and seg pins trail the slot counter by two cycles
	always_ff @(posedge clk) begin
		if (srst) begin
			slotD_r <= 4'h0;
			comPin_r <= 8'h00;
			segPin_r <= 32'h00000000;
			glassBias_r <= 2'b00;
			glassBrt_r <= 3'b000;
			refBoost_r <= 1'b0;
		end else begin
			slotD_r <= slot_r;
			comPin_r <= (comAct & comKeep) ^ {8{comPolEff}};
			segPin_r <= (segAct & segKeep) ^ {32{segPolEff}};
			glassBias_r <= isLcd ? cfgB_r[POS_BIAS +: 2] : 2'b00;
			glassBrt_r <= isLcd ? {ctlHigh_r[POS_GLASS_BRT_HI],
				cfgB_r[POS_GLASS_BRT_LO +: 2]} : 3'b000;
			refBoost_r <= boostNxt != 5'h00;
		end
	end

	assign regRdData = mi.rdData;
	assign comPin = comPin_r;
	assign segPin = segPin_r;
	assign frameIrq = frameIrq_r;
	assign glassBias = glassBias_r;
	assign glassBrightness = glassBrt_r;
	assign refBoost = refBoost_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_irq_equals_and: assert property (
		frameIrq == (flag_r && cfgA_r[POS_IRQ_EN]))
		else $error("frame request differs from flag and enable");

	a_frame_sets_flag: assert property (
		frameEnd |=> flag_r)
		else $error("frame end did not set the flag");

	a_flag_clear_tick: assert property (
		$fell(flag_r) |-> $past(clrPend_r) && $past(srcTick)
			&& !$past(frameEnd))
		else $error("flag dropped without a pending clear on a tick");

	a_blank_pins_off: assert property (
		cfgA_r[POS_BLANK] && !isExt |=> comPin == 8'h00
			&& segPin == 32'h00000000)
		else $error("pins active while blanked");

	a_off_pins_quiet: assert property (
		mode == LSC_OFF |=> comPin == 8'h00 && segPin == 32'h00000000
			&& slot_r == 4'h0)
		else $error("disabled controller still drives");

	a_slot_step_up: assert property (
		pixTick && !slotWrap |=> slot_r == $past(slot_r) + 4'h1)
		else $error("slot did not advance by one");

	a_slot_wrap_zero: assert property (
		frameEnd |=> slot_r == 4'h0)
		else $error("slot did not wrap to zero");

	a_led_prescale: assert property (
		isLed && srcTick && $past(isLed) |-> $past(pre_r) == 8'hFE)
		else $error("LED tick not on the 256th clock");

	a_div_wrap_zero: assert property (
		pixTick |=> divCnt_r == 12'h000)
		else $error("divider did not restart after pixel tick");

	a_boost_start: assert property (
		pixTick && isLcd && racVal != 4'h0 |=> refBoost ##0 refBoost)
		else $error("reference boost did not start");

	c_lcd_frame: cover property (frameEnd && isLcd);
	c_direct_frame: cover property (frameEnd && isDirect);
	c_flag_cleared: cover property ($fell(flag_r));
	c_irq_raised: cover property ($rose(frameIrq));

endmodule // lsc_scan_ctrl
`default_nettype wire

/* tb/lsc_panel_model.sv */
// glass panel model that latches segments under each lit common
`timescale 1ns/1ps
`default_nettype none
module lsc_panel_model (
	input wire logic clk,
	input wire logic clrSeen,
	input wire logic [7:0] comPin,
	input wire logic [31:0] segPin,
	output logic [7:0] comSeen,
	output logic [31:0] segSeen [8]
);
	// a one-hot common lights one row; anything else shows nothing
	always_ff @(posedge clk) begin
		for (int k = 0; k < 8; k++) begin
			if (clrSeen) begin
				comSeen[k] <= 1'b0;
			end else if (comPin == 8'(1 << k)) begin
				comSeen[k] <= 1'b1;
				segSeen[k] <= segPin;
			end
		end
	end
endmodule // lsc_panel_model
`default_nettype wire

/* tb/test_lsc_scan_ctrl.sv */
// self-checking testbench for the segment display scan controller
`timescale 1ns/1ps
`default_nettype none
module test_lsc_scan_ctrl import lsc_pkg::*; ;
	logic clk, srst, regWr, regRd, rtcClk, slowOscClk;
	logic clrSeen, rtcRun, oscRun, frameIrq, refBoost;
	logic [15:0] regAddr;
	logic [7:0] regWrData, regRdData, comPin, comSeen;
	logic [31:0] segPin, digits;
	logic [31:0] segSeen [8];
	logic [1:0] glassBias;
	logic [2:0] glassBrightness;
	logic [1:0] ph = 2'd0;
	int num_errors, tests_run, n, bad;
	int cycles = 0;

	lsc_scan_ctrl lsc_scan_ctrl_inst (.clk(clk), .srst(srst),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .rtcClk(rtcClk),
		.slowOscClk(slowOscClk), .comPin(comPin), .segPin(segPin),
		.frameIrq(frameIrq), .glassBias(glassBias),
		.glassBrightness(glassBrightness), .refBoost(refBoost));
	lsc_panel_model lsc_panel_model_inst (.clk(clk), .clrSeen(clrSeen),
		.comPin(comPin), .segPin(segPin), .comSeen(comSeen),
		.segSeen(segSeen));

	// ----------------------------------------
	// clocks and watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// slow clocks toggle every four cycles, stopped when not run
	always @(posedge clk) begin
		ph <= ph + 2'd1;
		if (ph == 2'd3) begin
			rtcClk <= rtcClk ^ rtcRun;
			slowOscClk <= slowOscClk ^ oscRun;
		end
	end
	// a hang counts as a mismatch
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			finish_test;
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	// read data appear in the cycle after the strobe and hold until the next read
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 check(32'(regRdData), 32'(e));
	endtask
	// length of one full slot, skipping the partial one
	task slot_len(output int len);
		logic [7:0] p;
		len = 0;
		@(posedge clk);
		p = comPin;
		for (int i = 0; i < 3000 && comPin === p; i++) @(posedge clk);
		p = comPin;
		while (comPin === p && len < 3000) begin
			@(posedge clk);
			len++;
		end
	endtask
	function automatic logic [31:0] col(input int k);
		logic [31:0] v;
		logic [7:0] b;
		for (int m = 0; m < 32; m++) begin
			b = 8'(m * 7 + 1);
			v[m] = b[k];
		end
		return v;
	endfunction
	task finish_test;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		srst = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 16'h0000;
		regWrData = 8'h00;
		rtcClk = 1'b0;
		slowOscClk = 1'b0;
		{rtcRun, oscRun, clrSeen} = 3'b001;
		num_errors = 0;
		tests_run = 0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		// whole map plus one unmapped place reads zero
		for (n = 0; n < 37; n++) rd(ADDR_DATA_BASE + 16'(n), 8'h00);
		rd(16'hA130, 8'h00);
		for (n = 0; n < 32; n++) wr(ADDR_DATA_BASE + 16'(n), 8'(n * 7 + 1));
		for (n = 0; n < 32; n++) rd(ADDR_DATA_BASE + 16'(n), 8'(n * 7 + 1));
		// lcd on the rtc, bias codes 1 to 3, duty of two
		wr(ADDR_DIV_HIGH, 8'h30);
		for (n = 1; n < 4; n++) begin
			wr(ADDR_CFG_B, 8'(n * 64 + 33));
			repeat (3) @(posedge clk);
			check(32'(glassBias), 32'(n));
		end
		check(32'(glassBrightness), 32'h6);
		wr(ADDR_CFG_A, 8'h02);
		rtcRun <= 1'b1;
		clrSeen <= 1'b0;
		repeat (200) @(posedge clk);
		check(32'(comSeen), 32'h03);
		for (n = 0; n < 2; n++) check(segSeen[n], col(n));
		check(32'(frameIrq), 32'h1);
		rd(ADDR_CFG_A, 8'h03);
		wr(ADDR_CFG_A, 8'h01);
		repeat (2) @(posedge clk);
		check(32'(frameIrq), 32'h0);
		// clear waits for a display tick; long divider avoids frame ends
		rtcRun <= 1'b0;
		wr(ADDR_DIV_LOW, 8'hFF);
		wr(ADDR_DIV_HIGH, 8'h3F);
		wr(ADDR_CFG_A, 8'h00);
		rd(ADDR_CFG_A, 8'h01);
		rtcRun <= 1'b1;
		repeat (20) @(posedge clk);
		rd(ADDR_CFG_A, 8'h00);
		// blanking keeps frames coming
		wr(ADDR_DIV_LOW, 8'h00);
		wr(ADDR_DIV_HIGH, 8'h30);
		wr(ADDR_CFG_A, 8'h08);
		repeat (100) @(posedge clk);
		check(32'(comPin), 32'h0);
		check(segPin, 32'h0);
		rd(ADDR_CFG_A, 8'h09);
		// divider of three on the slow oscillator, rtc stopped
		wr(ADDR_CFG_A, 8'h01);
		rtcRun <= 1'b0;
		oscRun <= 1'b1;
		wr(ADDR_DIV_LOW, 8'h03);
		wr(ADDR_DIV_HIGH, 8'hB0);
		slot_len(n);
		slot_len(n);
		check(32'(n), 32'd32);
		// boost of three ticks in each 32-cycle slot; COM7 and COM5
		// take over their shared pins, so SEG28 and SEG30 go quiet
		wr(ADDR_CFG_C, 8'h02);
		wr(ADDR_CFG_A, 8'hA1);
		repeat (40) @(posedge clk);
		bad = 0;
		digits = 32'h0;
		for (n = 0; n < 256; n++) begin
			@(posedge clk);
			digits = digits | segPin;
			if (refBoost === 1'b1) bad++;
		end
		check(32'(bad), 32'd192);
		check(32'(digits[31:28]), 32'h8);
		// led external: source bit set but system clock rules
		oscRun <= 1'b0;
		wr(ADDR_DIV_LOW, 8'h01);
		wr(ADDR_DIV_HIGH, 8'hC0);
		wr(ADDR_CFG_C, 8'h3F);
		slot_len(n);
		slot_len(n);
		check(32'(n), 32'd512);
		check(32'(refBoost), 32'h0);
		// level 15 lights 16 of 64 parts: 128 of two prescaler rounds
		wr(ADDR_CFG_C, 8'h0F);
		repeat (4) @(posedge clk);
		bad = 0;
		for (n = 0; n < 512; n++) begin
			@(posedge clk);
			if (comPin !== 8'h00) bad++;
		end
		check(32'(bad), 32'd128);
		// inverted polarity: blanked pins rest high
		wr(ADDR_CFG_C, 8'hC0);
		wr(ADDR_CFG_A, 8'h08);
		repeat (4) @(posedge clk);
		check(32'(comPin), 32'hFF);
		check(segPin, 32'hFFFFFFFF);
		// direct drive, two digits from SEG0
		wr(ADDR_CFG_A, 8'h01);
		wr(ADDR_CFG_C, 8'h3F);
		wr(ADDR_DIV_HIGH, 8'h60);
		repeat (8) @(posedge clk);
		digits = 32'h0;
		bad = 0;
		for (n = 0; n < 1200; n++) begin
			@(posedge clk);
			digits = digits | segPin;
			if (segPin === 32'h1 && comPin !== 8'h01) bad++;
			if (segPin === 32'h2 && comPin !== 8'h08) bad++;
		end
		check(digits, 32'h3);
		check(32'(bad), 32'h0);
		// mode off drops every pin
		wr(ADDR_DIV_HIGH, 8'h00);
		repeat (4) @(posedge clk);
		check(32'(comPin), 32'h0);
		check(segPin, 32'h0);
		finish_test;
	end
endmodule // test_lsc_scan_ctrl
`default_nettype wire
